/* fsk_front_end.sv */
// front end spi slave: dac sample loading and receive gain register
//
// Contract
// - each sample is one spi word loaded into the internal dac.
// - receive amplifier gains are writable over the spi link.
// - first stage gain bits 1:0 select 0.25, 0.5, 1, 2 V/V.
// - second stage gain bits 3:2 select 1, 4, 16, 64 V/V.
// - gain field resets to first stage 10, second stage 00.
// - combined four-bit gain spans 0.25 V/V to 128 V/V.
`include "fsk_front_end_params.svh"
`timescale 1ns/1ps
module fsk_front_end (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic dac_select,
	output logic miso,
	output logic miso_oe,
	output logic [`FE_DAC_WIDTH-1:0] dac_value,
	output logic dac_load,
	output logic dac_mode_active,
	output logic tx_enable,
	output logic power_amp_enable,
	output logic [1:0] first_stage_rx_gain,
	output logic [1:0] second_stage_rx_gain,
	output logic [3:0] combined_rx_gain_code,
	output logic [9:0] rx_gain_quarters
);
	fsk_front_end_pkg::spi_pins_s pins_s;
	fsk_front_end_pkg::frame_state_e state_q;
	fsk_front_end_pkg::rx_gain_code_s gain_code;
	logic sclk_prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic [`FE_CMD_WIDTH-1:0] shift_q;
	logic [4:0] bit_cnt_q;
	logic [7:0] tx_q;
	logic reading_q;
	logic [7:0] enable_q;
	logic [7:0] rx_gain_q;
	logic frame_write;
	logic [6:0] frame_addr;

	// gain times four is a single shift: stage1 1..8, stage2 1..64
	function automatic logic [9:0] gain_quarters(
		input fsk_front_end_pkg::rx_gain_code_s code
	);
		logic [3:0] sh;
		sh = {2'h0, code.first_stage} + {1'b0, code.second_stage, 1'b0};
		gain_quarters = 10'h001 << sh;
	endfunction : gain_quarters

	function automatic logic [7:0] reg_read(input logic [6:0] addr);
		reg_read = 8'h00;
		if (addr == `FE_ADDR_ENABLE) begin
			reg_read = enable_q;
		end else if (addr == `FE_ADDR_RX_GAIN) begin
			reg_read = rx_gain_q;
		end
	endfunction : reg_read

	// chip select resets to its idle high level, so no false frame opens
	pin_sync #(
		.WIDTH(4),
		.RESET_VAL(4'h2)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({dac_select, mosi, cs_n, sclk}),
		.sync_out(pins_s)
	);

	assign sclk_rise = pins_s.sclk & ~sclk_prev_q;
	assign sclk_fall = ~pins_s.sclk & sclk_prev_q;
	assign gain_code = rx_gain_q[3:0];
	assign frame_addr = shift_q[14:8];
	assign frame_write = (state_q == fsk_front_end_pkg::st_end)
		&& !pins_s.dac_select && (bit_cnt_q == `FE_CMD_WORD_BITS)
		&& !shift_q[`FE_CMD_WIDTH-1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= pins_s.sclk;
		end
	end

	// frame sequencing: chip select low opens, its rise closes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= fsk_front_end_pkg::st_idle;
		end else begin
			unique case (state_q)
				fsk_front_end_pkg::st_idle: begin
					if (!pins_s.cs_n) begin
						state_q <= fsk_front_end_pkg::st_shift;
					end
				end
				fsk_front_end_pkg::st_shift: begin
					if (pins_s.cs_n) begin
						state_q <= fsk_front_end_pkg::st_end;
					end
				end
				fsk_front_end_pkg::st_end: begin
					state_q <= fsk_front_end_pkg::st_idle;
				end
				default: begin
					state_q <= fsk_front_end_pkg::st_idle;
				end
			endcase
		end
	end

	// msb first, mosi taken on sclk rise; count saturates on long frames
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 16'h0000;
			bit_cnt_q <= 5'h00;
		end else if (state_q == fsk_front_end_pkg::st_idle) begin
			bit_cnt_q <= 5'h00;
		end else if (state_q == fsk_front_end_pkg::st_shift && sclk_rise) begin
			shift_q <= {shift_q[`FE_CMD_WIDTH-2:0], pins_s.mosi};
			if (bit_cnt_q != 5'h1f) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end

	// read data shifted out on sclk fall after the 8-bit header
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= 8'h00;
			reading_q <= 1'b0;
			miso <= 1'b0;
			miso_oe <= 1'b0;
		end else if (state_q != fsk_front_end_pkg::st_shift || pins_s.cs_n
			|| pins_s.dac_select) begin
			reading_q <= 1'b0;
			miso <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			miso_oe <= 1'b1;
			if (sclk_rise && bit_cnt_q == `FE_CMD_HEAD_BITS - 5'h01) begin
				reading_q <= shift_q[6];
				tx_q <= reg_read({shift_q[5:0], pins_s.mosi});
			end else if (sclk_fall && reading_q) begin
				miso <= tx_q[7];
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// a 10-bit frame in dac mode is one sample for the dac
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_value <= 10'h000;
			dac_load <= 1'b0;
		end else begin
			dac_load <= 1'b0;
			if (state_q == fsk_front_end_pkg::st_end && pins_s.dac_select
				&& bit_cnt_q == `FE_DAC_WORD_BITS) begin
				dac_value <= shift_q[`FE_DAC_WIDTH-1:0];
				dac_load <= 1'b1;
			end
		end
	end

	// write-only-on-whole-frame: a short or long frame changes nothing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= `FE_ENABLE_RESET;
			rx_gain_q <= `FE_RX_GAIN_RESET;
		end else if (frame_write) begin
			if (frame_addr == `FE_ADDR_ENABLE) begin
				enable_q <= shift_q[7:0];
			end else if (frame_addr == `FE_ADDR_RX_GAIN) begin
				rx_gain_q <= shift_q[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_enable <= 1'b0;
			power_amp_enable <= 1'b0;
			dac_mode_active <= 1'b0;
			first_stage_rx_gain <= 2'h2;
			second_stage_rx_gain <= 2'h0;
			combined_rx_gain_code <= 4'h2;
			rx_gain_quarters <= 10'h004;
		end else begin
			tx_enable <= enable_q[`FE_EN_TX_BIT];
			power_amp_enable <= enable_q[`FE_EN_PA_BIT];
			dac_mode_active <= enable_q[`FE_EN_TX_BIT]
				& enable_q[`FE_EN_PA_BIT] & pins_s.dac_select;
			first_stage_rx_gain <= gain_code.first_stage;
			second_stage_rx_gain <= gain_code.second_stage;
			combined_rx_gain_code <= rx_gain_q[3:0];
			rx_gain_quarters <= gain_quarters(gain_code);
		end
	end

	logic gain_written_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_written_q <= 1'b0;
		end else if (frame_write && frame_addr == `FE_ADDR_RX_GAIN) begin
			gain_written_q <= 1'b1;
		end
	end

	chk_gain_default: assert property (@(posedge clk) disable iff (!rst_n)
		!gain_written_q |-> rx_gain_q[3:0] == 4'h2)
		else $error("gain field lost its reset value");
	chk_gain_write: assert property (@(posedge clk) disable iff (!rst_n)
		frame_write && frame_addr == `FE_ADDR_RX_GAIN
		|=> rx_gain_q == $past(shift_q[7:0]))
		else $error("gain write not stored");
	chk_first_stage: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(rx_gain_q) |-> first_stage_rx_gain == rx_gain_q[1:0])
		else $error("first stage gain field wrong");
	chk_second_stage: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(rx_gain_q) |-> second_stage_rx_gain == rx_gain_q[3:2])
		else $error("second stage gain field wrong");
	chk_gain_max: assert property (@(posedge clk) disable iff (!rst_n)
		rx_gain_q[3:0] == 4'hf ##1 rx_gain_q[3:0] == 4'hf
		|-> rx_gain_quarters == 10'h200)
		else $error("top gain code not 128 V/V");
	chk_gain_min: assert property (@(posedge clk) disable iff (!rst_n)
		rx_gain_q[3:0] == 4'h0 ##1 rx_gain_q[3:0] == 4'h0
		|-> rx_gain_quarters == 10'h001)
		else $error("zero gain code not 0.25 V/V");
	chk_dac_value: assert property (@(posedge clk) disable iff (!rst_n)
		dac_load |-> dac_value == $past(shift_q[9:0])
		&& $past(bit_cnt_q) == `FE_DAC_WORD_BITS)
		else $error("dac loaded with wrong word");
	chk_dac_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		dac_load |=> !dac_load)
		else $error("dac load longer than one cycle");
	chk_miso_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		pins_s.cs_n [*2] |-> !miso_oe)
		else $error("miso driven while deselected");

	cov_dac_load: cover property (@(posedge clk) disable iff (!rst_n)
		dac_load);
	cov_gain_write: cover property (@(posedge clk) disable iff (!rst_n)
		frame_write && frame_addr == `FE_ADDR_RX_GAIN);
	cov_reg_read: cover property (@(posedge clk) disable iff (!rst_n)
		reading_q && sclk_fall);
endmodule : fsk_front_end

/* fsk_front_end_params.svh */
// constants of the powerline front end spi register and dac slave
`ifndef FSK_FRONT_END_PARAMS_SVH
`define FSK_FRONT_END_PARAMS_SVH

`define FE_ADDR_ENABLE 7'h00
`define FE_ADDR_RX_GAIN 7'h01
`define FE_ENABLE_RESET 8'h00
`define FE_RX_GAIN_RESET 8'h02
`define FE_EN_TX_BIT 0
`define FE_EN_PA_BIT 1
`define FE_FIRST_STAGE_RX_GAIN_LSB 0
`define FE_SECOND_STAGE_RX_GAIN_LSB 2
`define FE_DAC_WORD_BITS 5'h0a
`define FE_CMD_WORD_BITS 5'h10
`define FE_CMD_HEAD_BITS 5'h08
`define FE_DAC_WIDTH 10
`define FE_CMD_WIDTH 16

`endif

/* fsk_front_end_pkg.sv */
// types shared by the front end slave
package fsk_front_end_pkg;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_shift = 2'b01,
		st_end = 2'b11
	} frame_state_e;

	typedef struct packed {
		logic dac_select;
		logic mosi;
		logic cs_n;
		logic sclk;
	} spi_pins_s;

	typedef struct packed {
		logic [1:0] second_stage;
		logic [1:0] first_stage;
	} rx_gain_code_s;

endpackage : fsk_front_end_pkg

/* pin_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pin_sync

/* spi_host_model.sv */
// spi host model standing in for the transmitter on the link pins
`timescale 1ns/1ps
module spi_host_model (
	output fsk_front_end_pkg::spi_pins_s pins,
	input wire logic miso
);
	initial begin
		pins = '0;
		pins.cs_n = 1'b1;
	end
	// one frame, msb first; sclk stands low outside frames
	task automatic xfer(input int n, input logic [15:0] w,
		output logic [15:0] r);
		r = 16'h0000;
		pins.cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			pins.mosi = w[i];
			#62.5 pins.sclk = 1'b1;
			r = {r[14:0], miso};
			#62.5 pins.sclk = 1'b0;
		end
		#62.5 pins.cs_n = 1'b1;
		// released data line must not keep its last level
		pins.mosi = ~pins.mosi;
		#100;
	endtask : xfer
	// held steady between frames only
	task automatic mode(input logic dac);
		pins.dac_select = dac;
	endtask : mode
endmodule : spi_host_model

/* test_fsk_front_end.sv */
// self-checking bench for the front end spi slave
`timescale 1ns/1ps
module test_fsk_front_end;
	logic clk;
	logic rst_n;
	fsk_front_end_pkg::spi_pins_s pins;
	logic miso, miso_oe, miso_w, dac_load, dac_mode_active;
	logic tx_enable, power_amp_enable;
	logic [9:0] dac_value, rx_gain_quarters, s;
	logic [1:0] first_stage_rx_gain, second_stage_rx_gain;
	logic [3:0] combined_rx_gain_code;
	logic [9:0] dac_q[$];
	logic [15:0] rd;
	logic [7:0] g;
	int fails, checks_done;
	localparam real RATE_HZ = 1.0e6;
	localparam real MARK_HZ = 131.25e3;
	localparam real SPACE_HZ = 143.75e3;
	// slowed from 1 us: a 10-bit frame on the 125 ns link needs 1.41 us
	localparam real TICK_NS = 1500.0;
	// arbitrary 11-bit mark/space patterns, 1 = mark
	localparam logic [10:0] ONE_WORD = 11'h5a3;
	localparam logic [10:0] ZERO_WORD = 11'h2c6;
	real phase_position, phase_increment, mark_step, space_step;
	logic packet_select;
	logic [9:0] sbuf[4];
	assign miso_w = (miso_oe === 1'b1) ? miso : 1'bz;
	fsk_front_end u_fsk_front_end (.clk(clk), .rst_n(rst_n),
		.sclk(pins.sclk), .cs_n(pins.cs_n), .mosi(pins.mosi),
		.dac_select(pins.dac_select), .miso(miso), .miso_oe(miso_oe),
		.dac_value(dac_value), .dac_load(dac_load),
		.dac_mode_active(dac_mode_active), .tx_enable(tx_enable),
		.power_amp_enable(power_amp_enable),
		.first_stage_rx_gain(first_stage_rx_gain),
		.second_stage_rx_gain(second_stage_rx_gain),
		.combined_rx_gain_code(combined_rx_gain_code),
		.rx_gain_quarters(rx_gain_quarters));
	spi_host_model u_spi_host_model (.pins(pins), .miso(miso_w));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		u_spi_host_model.xfer(16, {1'b0, a, d}, rd);
	endtask : wr
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		@(negedge clk);
		u_spi_host_model.xfer(16, {1'b1, a, 8'h00}, rd);
		chk({8'h00, rd[7:0]}, {8'h00, e});
		chk({15'h0, miso_oe}, 16'h0000);
	endtask : rdchk
	task automatic gchk(input logic [3:0] c);
		chk({14'h0, first_stage_rx_gain}, {14'h0, c[1:0]});
		chk({14'h0, second_stage_rx_gain}, {14'h0, c[3:2]});
		chk({12'h0, combined_rx_gain_code}, {12'h0, c});
		chk({6'h0, rx_gain_quarters},
			16'h0001 << (c[1:0] + 2 * c[3:2]));
	endtask : gchk
	task automatic enchk(input logic [2:0] e);
		chk({13'h0, dac_mode_active, power_amp_enable, tx_enable},
			{13'h0, e});
	endtask : enchk
	// table read at the integer part; the fraction stays in the position
	function automatic logic [9:0] next_sample();
		int idx;
		idx = $rtoi(phase_position);
		next_sample = 10'($rtoi(511.0 + 511.0
			* $sin(6.283185307179586 * idx / 4096.0)));
		phase_position = phase_position + phase_increment;
		if (phase_position > 4095.0) begin
			phase_position = phase_position - 4095.0;
		end
	endfunction : next_sample
	// transmitter stand-in: two buffers feed one frame per tick for the first 33 ticks of each 209
	task automatic stream(input int periods);
		realtime t0;
		int cnt;
		int act;
		int rdi;
		logic [10:0] word;
		cnt = 0;
		act = 0;
		rdi = 0;
		packet_select = 1'b1;
		for (int p = 0; p < periods; p++) begin
			t0 = $realtime;
			if (cnt == 209) begin
				cnt = 0;
				packet_select = 1'b0;
			end
			if (cnt < 33) begin
				word = packet_select ? ONE_WORD : ZERO_WORD;
				phase_increment = word[10 - cnt % 11] ? mark_step
					: space_step;
				if (cnt == 0) begin
					phase_position = 0.0;
					act = 0;
					rdi = 0;
					for (int j = 0; j < 4; j++) begin
						sbuf[j] = next_sample();
					end
				end
				s = sbuf[2 * act + rdi];
				dac_q.push_back(s);
				u_spi_host_model.xfer(10, {6'h0, s}, rd);
				rdi++;
				if (rdi == 2) begin
					sbuf[2 * act] = next_sample();
					sbuf[2 * act + 1] = next_sample();
					act = 1 - act;
					rdi = 0;
				end
			end else if (cnt == 100) begin
				chk({6'h0, dac_value}, {6'h0, s});
			end
			cnt++;
			#(TICK_NS - ($realtime - t0));
		end
	endtask : stream
	// loads are matched against the oldest noted sample
	always @(negedge clk) begin
		if (dac_load === 1'b1) begin
			if (dac_q.size() == 0) begin
				chk(16'hffff, 16'h0000);
			end else begin
				chk({6'h0, dac_value}, {6'h0, dac_q.pop_front()});
			end
		end
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#900000;
		fails++;
		tally_and_finish();
	end
	initial begin
		fails = 0;
		checks_done = 0;
		rst_n = 1'b0;
		void'($urandom(32'h781a_a626));
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		gchk(4'h2);
		enchk(3'h0);
		rdchk(7'h01, 8'h02);
		for (int c = 0; c < 16; c++) begin
			g = 8'($urandom());
			g[3:0] = 4'(c);
			wr(7'h01, g);
			gchk(g[3:0]);
			rdchk(7'h01, g);
		end
		// unmapped place: write dropped, read gives zero
		wr(7'h05, 8'hff);
		rdchk(7'h05, 8'h00);
		rdchk(7'h01, g);
		wr(7'h00, 8'h03);
		rdchk(7'h00, 8'h03);
		enchk(3'h3);
		@(negedge clk);
		u_spi_host_model.mode(1'b1);
		repeat (8) @(negedge clk);
		enchk(3'h7);
		for (int i = 0; i < 6; i++) begin
			if (i == 3) begin
				// short frame must be dropped without a load
				@(negedge clk);
				u_spi_host_model.xfer(9, 16'h01ff, rd);
			end
			s = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($urandom());
			dac_q.push_back(s);
			@(negedge clk);
			u_spi_host_model.xfer(10, {6'h0, s}, rd);
		end
		for (int i = 0; i < 20 && dac_q.size() > 0; i++) @(negedge clk);
		chk(16'(dac_q.size()), 16'h0000);
		mark_step = 4096.0 / (RATE_HZ / MARK_HZ);
		space_step = 4096.0 / (RATE_HZ / SPACE_HZ);
		chk(16'($rtoi(mark_step)), 16'h0219);
		stream(242);
		chk(16'(dac_q.size()), 16'h0000);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		gchk(4'h2);
		enchk(3'h0);
		tally_and_finish();
	end
endmodule : test_fsk_front_end
